// *** pmx_pkg.sv ***
// package: register map, pin map and carrier types of the port pin mux
package pmx_pkg;
   // ---------------------------------------------------------------
   // register addresses, reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] PMX_ADDR_PORT0  = 8'h80;
   localparam logic [7:0] PMX_ADDR_PORT1  = 8'h90;
   localparam logic [7:0] PMX_ADDR_PORT2  = 8'hA0;
   localparam logic [7:0] PMX_ADDR_LOCSEL = 8'hF1;
   localparam logic [7:0] PMX_PORT01_RESET = 8'hFF;
   localparam logic [7:0] PMX_PORT2_RESET  = 8'h1F;
   localparam logic [7:0] PMX_LOCSEL_RESET = 8'h00;
   localparam logic [7:0] PMX_LOCSEL_MASK  = 8'h73;
   localparam int PMX_BIT_U0LOC = 0;
   localparam int PMX_BIT_U1LOC = 1;
   localparam int PMX_BIT_T4LOC = 4;
   localparam int PMX_BIT_T3LOC = 5;
   localparam int PMX_BIT_T1LOC = 6;
   localparam int PMX_PORT2_W   = 5;
   // ---------------------------------------------------------------
   // peripherals, pins and routing table
   // ---------------------------------------------------------------
   localparam int PMX_PER_CNT = 6;
   localparam int PMX_SIG_CNT = 4;
   localparam int PMX_PIN_CNT = 21;
   localparam int PMX_U0  = 0;
   localparam int PMX_U1  = 1;
   localparam int PMX_T1  = 2;
   localparam int PMX_T3  = 3;
   localparam int PMX_T4  = 4;
   localparam int PMX_I2S = 5;
   localparam logic [4:0] PMX_NONE     = 5'h1F;
   localparam logic [4:0] PMX_PIN_TRIG = 5'h10;
   localparam logic [4:0] PMX_PIN_DDAT = 5'h11;
   localparam logic [4:0] PMX_PIN_DCLK = 5'h12;
   localparam logic [4:0] PMX_PIN_XO1  = 5'h13;
   localparam logic [4:0] PMX_PIN_XO2  = 5'h14;
   // serial units in asynchronous mode only use signals 0 (rx) and 1 (tx)
   localparam logic [3:0] PMX_UART_USED = 4'h3;
   localparam logic [3:0] PMX_SIG_USED [PMX_PER_CNT] =
      '{4'hF, 4'hF, 4'h7, 4'h3, 4'h3, 4'hF};
   // pin id = port * 8 + bit; [peripheral][location][signal]
   localparam logic [4:0] PMX_MAP [PMX_PER_CNT][2][PMX_SIG_CNT] = '{
      '{'{5'h02, 5'h03, 5'h04, 5'h05}, '{5'h0D, 5'h0C, 5'h0A, 5'h0B}},
      '{'{5'h05, 5'h04, 5'h02, 5'h03}, '{5'h0F, 5'h0E, 5'h0C, 5'h0D}},
      '{'{5'h02, 5'h03, 5'h04, 5'h1F}, '{5'h0A, 5'h09, 5'h08, 5'h1F}},
      '{'{5'h0B, 5'h0C, 5'h1F, 5'h1F}, '{5'h0E, 5'h0F, 5'h1F, 5'h1F}},
      '{'{5'h08, 5'h09, 5'h1F, 5'h1F}, '{5'h10, 5'h13, 5'h1F, 5'h1F}},
      '{'{5'h00, 5'h01, 5'h06, 5'h07}, '{5'h0A, 5'h0B, 5'h0E, 5'h0F}}
   };
   // ---------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PMX_SIG_CNT-1:0] o;
      logic [PMX_SIG_CNT-1:0] oe;
   } pmx_drive_t;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic       rmw;
      logic [7:0] wdata;
      logic       bit_wr;
      logic [2:0] bit_idx;
      logic       bit_val;
   } pmx_sfr_req_t;
   typedef struct packed {
      logic [1:0] port0_precedence_field;
      logic       port1_precedence_bit_three;
      logic       port1_precedence_bit_two;
      logic       port1_precedence_bit_one;
      logic       port1_precedence_bit_zero;
   } pmx_prec_t;
endpackage

// *** pmx_port_reg.sv ***
// bit- and byte-writable port data register
`timescale 1ns/1ps
`default_nettype none
module pmx_port_reg #(
   parameter int         WIDTH = 8,
   parameter logic [7:0] RESET = 8'hFF
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             wr,
   input  wire logic [7:0]       wdata,
   input  wire logic             bit_wr,
   input  wire logic [2:0]       bit_idx,
   input  wire logic             bit_val,
   output logic      [WIDTH-1:0] q
);
   if (WIDTH < 1 || WIDTH > 8) begin : g_bad
      $error("pmx_port_reg: WIDTH must be 1 to 8");
   end

   // a bit write beyond the implemented width is dropped
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= RESET[WIDTH-1:0];
      end else if (wr) begin
         q <= wdata[WIDTH-1:0];
      end else if (bit_wr && int'(bit_idx) < WIDTH) begin
         q[bit_idx] <= bit_val;
      end
   end
endmodule
`default_nettype wire

// *** pmx_pin_cell.sv ***
// one pad's output stage: override order and registered drive
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_cell (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic analog_en,
   input  wire logic dbg_en,
   input  wire logic dbg_o,
   input  wire logic dbg_oe,
   input  wire logic func_sel,
   input  wire logic per_valid,
   input  wire logic per_o,
   input  wire logic per_oe,
   input  wire logic gpio_o,
   input  wire logic gpio_dir,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_analog
);
   logic next_out;
   logic next_oe;

   always_comb begin
      next_out = 1'b0;
      next_oe  = 1'b0;
      if (analog_en) begin
         next_oe = 1'b0;
      end else if (dbg_en) begin
         next_out = dbg_o;
         next_oe  = dbg_oe;
      end else if (func_sel) begin
         // peripheral function with no claimant leaves the pad floating in
         next_out = per_valid & per_o;
         next_oe  = per_valid & per_oe;
      end else begin
         next_out = gpio_o;
         next_oe  = gpio_dir;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pad_out    <= 1'b0;
         pad_oe     <= 1'b0;
         pad_analog <= 1'b0;
      end else begin
         pad_out    <= next_out;
         pad_oe     <= next_oe;
         pad_analog <= analog_en;
      end
   end
endmodule
`default_nettype wire

// *** pmx_pin_mux.sv ***
// port pin mux: data and location registers, precedence, pad stages
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_mux (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_b,
   input  wire pmx_pkg::pmx_sfr_req_t      sfr_req,
   output logic      [7:0]                 sfr_rdata,
   input  wire logic [20:0]                pad_in,
   output logic      [20:0]                pad_out,
   output logic      [20:0]                pad_oe,
   output logic      [20:0]                pad_analog,
   input  wire logic [20:0]                port_function_select,
   input  wire logic [20:0]                port_direction,
   input  wire pmx_pkg::pmx_prec_t         prec,
   input  wire logic [1:0]                 usart_uart_mode,
   input  wire logic [5:0]                 periph_enable,
   input  wire logic                       audio_serial_location,
   input  wire logic [7:0]                 analog_input_enable,
   input  wire logic                       low_freq_osc_select,
   input  wire logic                       debug_active,
   input  wire logic                       debug_data_out,
   input  wire logic                       debug_data_oe,
   input  wire pmx_pkg::pmx_drive_t [5:0]  periph_drive,
   output logic      [5:0][3:0]            periph_pin_in,
   output logic      [7:0]                 converter_inputs,
   output logic                            debug_data_in,
   output logic                            debug_clock_in,
   output logic                            conv_trigger_in
);
   import pmx_pkg::*;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0]            port0_q;
   logic [7:0]            port1_q;
   logic [PMX_PORT2_W-1:0] port2_q;
   logic [7:0]            peripheral_location_select;
   logic [2:0]            port_wr;
   logic [2:0]            port_bit_wr;
   logic [7:0]            port_addr [3];

   assign port_addr[0] = PMX_ADDR_PORT0;
   assign port_addr[1] = PMX_ADDR_PORT1;
   assign port_addr[2] = PMX_ADDR_PORT2;

   for (genvar p = 0; p < 3; p++) begin : g_dec
      assign port_wr[p]     = sfr_req.wr && sfr_req.addr == port_addr[p];
      assign port_bit_wr[p] = sfr_req.bit_wr && sfr_req.addr == port_addr[p];
   end

   pmx_port_reg #(.WIDTH(8), .RESET(PMX_PORT01_RESET)) u_port0 (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .wr      (port_wr[0]),
      .wdata   (sfr_req.wdata),
      .bit_wr  (port_bit_wr[0]),
      .bit_idx (sfr_req.bit_idx),
      .bit_val (sfr_req.bit_val),
      .q       (port0_q)
   );
   pmx_port_reg #(.WIDTH(8), .RESET(PMX_PORT01_RESET)) u_port1 (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .wr      (port_wr[1]),
      .wdata   (sfr_req.wdata),
      .bit_wr  (port_bit_wr[1]),
      .bit_idx (sfr_req.bit_idx),
      .bit_val (sfr_req.bit_val),
      .q       (port1_q)
   );
   pmx_port_reg #(.WIDTH(PMX_PORT2_W), .RESET(PMX_PORT2_RESET)) u_port2 (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .wr      (port_wr[2]),
      .wdata   (sfr_req.wdata),
      .bit_wr  (port_bit_wr[2]),
      .bit_idx (sfr_req.bit_idx),
      .bit_val (sfr_req.bit_val),
      .q       (port2_q)
   );

   // location register is byte access only; unused bits stay zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         peripheral_location_select <= PMX_LOCSEL_RESET;
      end else if (sfr_req.wr && sfr_req.addr == PMX_ADDR_LOCSEL) begin
         peripheral_location_select <= sfr_req.wdata & PMX_LOCSEL_MASK;
      end
   end

   // plain port reads return pad levels, read-modify-write reads the latch
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            PMX_ADDR_PORT0:  sfr_rdata <= sfr_req.rmw ? port0_q : pad_in[7:0];
            PMX_ADDR_PORT1:  sfr_rdata <= sfr_req.rmw ? port1_q : pad_in[15:8];
            PMX_ADDR_PORT2:  sfr_rdata <= {3'b000, sfr_req.rmw ? port2_q : pad_in[20:16]};
            PMX_ADDR_LOCSEL: sfr_rdata <= peripheral_location_select;
            default:         sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // location decode
   // ---------------------------------------------------------------
   logic       serial_unit0_location;
   logic       serial_unit1_location;
   logic       timer1_location;
   logic       timer3_location;
   logic       timer4_location;
   logic [5:0] loc;

   assign serial_unit0_location = peripheral_location_select[PMX_BIT_U0LOC];
   assign serial_unit1_location = peripheral_location_select[PMX_BIT_U1LOC];
   assign timer1_location       = peripheral_location_select[PMX_BIT_T1LOC];
   assign timer3_location       = peripheral_location_select[PMX_BIT_T3LOC];
   assign timer4_location       = peripheral_location_select[PMX_BIT_T4LOC];
   assign loc = {audio_serial_location, timer4_location, timer3_location,
                 timer1_location, serial_unit1_location, serial_unit0_location};

   // ---------------------------------------------------------------
   // precedence
   // ---------------------------------------------------------------
   function automatic int rank0(input int p, input logic [1:0] field);
      int r;
      r = p + 3;
      unique case (field)
         2'b00: r = (p == PMX_U0) ? 0 : (p == PMX_U1) ? 1 : (p == PMX_T1) ? 2 : r;
         2'b01: r = (p == PMX_U1) ? 0 : (p == PMX_U0) ? 1 : (p == PMX_T1) ? 2 : r;
         2'b10, 2'b11: r = (p == PMX_T1) ? 0 : (p == PMX_U0) ? 1 : (p == PMX_U1) ? 2 : r;
      endcase
      return r;
   endfunction

   // true when peripheral a takes a pin that b also claims
   function automatic logic beats(input int a, input int b, input int port,
                                  input pmx_prec_t pr);
      logic r;
      r = a < b;
      if (port == 0) begin
         r = rank0(a, pr.port0_precedence_field) < rank0(b, pr.port0_precedence_field);
      end else if (port == 1) begin
         if (a == PMX_U0 && b == PMX_U1) r = !pr.port1_precedence_bit_three;
         if (a == PMX_U1 && b == PMX_U0) r = pr.port1_precedence_bit_three;
         if (a == PMX_U0 && b == PMX_T1) r = !pr.port1_precedence_bit_zero;
         if (a == PMX_T1 && b == PMX_U0) r = pr.port1_precedence_bit_zero;
         if (a == PMX_T1 && b == PMX_T4) r = !pr.port1_precedence_bit_one;
         if (a == PMX_T4 && b == PMX_T1) r = pr.port1_precedence_bit_one;
         if (a == PMX_U1 && b == PMX_T3) r = !pr.port1_precedence_bit_two;
         if (a == PMX_T3 && b == PMX_U1) r = pr.port1_precedence_bit_two;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // claims and winner per pin
   // ---------------------------------------------------------------
   logic [PMX_PIN_CNT-1:0][PMX_PER_CNT-1:0] claim;
   logic [PMX_PIN_CNT-1:0][PMX_PER_CNT-1:0][1:0] claim_sig;
   logic [PMX_PIN_CNT-1:0] win_valid;
   logic [PMX_PIN_CNT-1:0] win_o;
   logic [PMX_PIN_CNT-1:0] win_oe;

   always_comb begin
      logic [3:0] used;
      logic [4:0] id;
      claim     = '0;
      claim_sig = '0;
      used      = 4'h0;
      id        = PMX_NONE;
      for (int p = 0; p < PMX_PER_CNT; p++) begin
         used = PMX_SIG_USED[p];
         if (p <= PMX_U1 && usart_uart_mode[p]) used = PMX_UART_USED;
         for (int s = 0; s < PMX_SIG_CNT; s++) begin
            id = PMX_MAP[p][loc[p]][s];
            if (periph_enable[p] && used[s] && id != PMX_NONE) begin
               claim[id][p]     = 1'b1;
               claim_sig[id][p] = 2'(s);
            end
         end
      end
   end

   // a claimant beaten by nobody wins; a precedence loop falls back to
   // the lowest peripheral number rather than leaving the pin undriven
   always_comb begin
      int  w;
      logic ok;
      w         = 0;
      ok        = 1'b0;
      win_valid = '0;
      win_o     = '0;
      win_oe    = '0;
      for (int n = 0; n < PMX_PIN_CNT; n++) begin
         w = -1;
         for (int p = PMX_PER_CNT - 1; p >= 0; p--) begin
            if (claim[n][p]) w = p;
         end
         for (int p = PMX_PER_CNT - 1; p >= 0; p--) begin
            ok = claim[n][p];
            for (int q = 0; q < PMX_PER_CNT; q++) begin
               if (q != p && claim[n][q] && beats(q, p, n / 8, prec)) ok = 1'b0;
            end
            if (ok) w = p;
         end
         if (w >= 0) begin
            win_valid[n] = 1'b1;
            win_o[n]     = periph_drive[w].o[claim_sig[n][w]];
            win_oe[n]    = periph_drive[w].oe[claim_sig[n][w]];
         end
      end
   end

   // ---------------------------------------------------------------
   // overrides and pad stages
   // ---------------------------------------------------------------
   logic [PMX_PIN_CNT-1:0] analog_en;
   logic [PMX_PIN_CNT-1:0] dbg_en;
   logic [PMX_PIN_CNT-1:0] gpio_o;

   assign gpio_o = {port2_q, port1_q, port0_q};

   for (genvar n = 0; n < PMX_PIN_CNT; n++) begin : g_pin
      if (n < 8) begin : g_adc
         assign analog_en[n] = analog_input_enable[n];
      end else if (n == PMX_PIN_XO1 || n == PMX_PIN_XO2) begin : g_xo
         assign analog_en[n] = !low_freq_osc_select;
      end else begin : g_dig
         assign analog_en[n] = 1'b0;
      end
      assign dbg_en[n] = debug_active && (n == PMX_PIN_DDAT || n == PMX_PIN_DCLK);
      pmx_pin_cell u_cell (
         .sys_clk    (sys_clk),
         .rst_b      (rst_b),
         .analog_en  (analog_en[n]),
         .dbg_en     (dbg_en[n]),
         .dbg_o      (debug_data_out),
         .dbg_oe     (debug_data_oe && n == PMX_PIN_DDAT),
         .func_sel   (port_function_select[n]),
         .per_valid  (win_valid[n]),
         .per_o      (win_o[n]),
         .per_oe     (win_oe[n]),
         .gpio_o     (gpio_o[n]),
         .gpio_dir   (port_direction[n]),
         .pad_out    (pad_out[n]),
         .pad_oe     (pad_oe[n]),
         .pad_analog (pad_analog[n])
      );
   end

   // ---------------------------------------------------------------
   // inputs seen by peripherals, debug and converter
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         periph_pin_in <= '0;
      end else begin
         for (int p = 0; p < PMX_PER_CNT; p++) begin
            for (int s = 0; s < PMX_SIG_CNT; s++) begin
               if (PMX_MAP[p][loc[p]][s] != PMX_NONE) begin
                  periph_pin_in[p][s] <= pad_in[PMX_MAP[p][loc[p]][s]];
               end else begin
                  periph_pin_in[p][s] <= 1'b0;
               end
            end
         end
      end
   end

   // the trigger pin is read as-is; keeping it a gpio input is software's job
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         converter_inputs <= 8'h00;
         debug_data_in    <= 1'b0;
         debug_clock_in   <= 1'b0;
         conv_trigger_in  <= 1'b0;
      end else begin
         converter_inputs <= analog_input_enable;
         debug_data_in    <= pad_in[PMX_PIN_DDAT];
         debug_clock_in   <= pad_in[PMX_PIN_DCLK];
         conv_trigger_in  <= pad_in[PMX_PIN_TRIG];
      end
   end
endmodule
`default_nettype wire

// *** pmx_pin_mux_asserts.sv ***
// checker: port timing relations of the pin mux
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_mux_chk (
   input wire logic                  sys_clk,
   input wire logic                  rst_b,
   input wire pmx_pkg::pmx_sfr_req_t sfr_req,
   input wire logic [7:0]            sfr_rdata,
   input wire logic [20:0]           pad_in,
   input wire logic [20:0]           pad_oe,
   input wire logic [20:0]           pad_analog,
   input wire logic [20:0]           port_function_select,
   input wire logic [20:0]           port_direction,
   input wire logic [7:0]            analog_input_enable,
   input wire logic                  low_freq_osc_select,
   input wire logic                  debug_active,
   input wire logic                  debug_data_oe,
   input wire logic [7:0]            converter_inputs,
   input wire logic                  audio_serial_location,
   input wire logic [5:0][3:0]       periph_pin_in,
   input wire logic                  debug_data_in,
   input wire logic                  debug_clock_in,
   input wire logic                  conv_trigger_in
);
   import pmx_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // the $past(rst_b) guards skip the first edge after reset release
   a_analog_pins: assert property ($past(rst_b) |->
      pad_analog[7:0] == $past(analog_input_enable)
      && (pad_oe[7:0] & $past(analog_input_enable)) == 8'h00) else $error("analog pins wrong");
   a_adc_copy: assert property ($past(rst_b) |->
      converter_inputs == $past(analog_input_enable)) else $error("converter select wrong");
   a_debug_pins: assert property ($past(rst_b) && $past(debug_active) |->
      pad_oe[17] == $past(debug_data_oe) && !pad_oe[18]) else $error("debug pins wrong");
   a_crystal_pins: assert property ($past(rst_b) && !$past(low_freq_osc_select) |->
      pad_analog[20:19] == 2'h3 && pad_oe[20:19] == 2'h0) else $error("crystal pins wrong");
   a_gpio_drive: assert property ($past(rst_b) && $past(port_function_select[15:8]) == 8'h00
      |-> pad_oe[15:8] == $past(port_direction[15:8])) else $error("gpio enable wrong");
   a_read_pins: assert property (sfr_req.rd && !sfr_req.rmw && sfr_req.addr == 8'h90
      |=> sfr_rdata == $past(pad_in[15:8])) else $error("pin read wrong");
   a_read_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved");
   a_locsel_spare: assert property (sfr_req.rd && sfr_req.addr == 8'hF1
      |=> sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'h0) else $error("spare bits set");
   a_pin_inputs: assert property ($past(rst_b) |->
      {debug_clock_in, debug_data_in, conv_trigger_in} == $past(pad_in[18:16])
      && periph_pin_in[5][0] == $past(audio_serial_location ? pad_in[10] : pad_in[0]))
      else $error("pin inputs wrong");
   c_debug: cover property (debug_active && debug_data_oe);
   c_crystal: cover property (!low_freq_osc_select);
   c_pin_read: cover property (sfr_req.rd && !sfr_req.rmw);
endmodule
bind pmx_pin_mux pmx_pin_mux_chk u_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .pad_in(pad_in), .pad_oe(pad_oe), .pad_analog(pad_analog),
   .port_function_select(port_function_select), .port_direction(port_direction),
   .analog_input_enable(analog_input_enable), .low_freq_osc_select(low_freq_osc_select),
   .debug_active(debug_active), .debug_data_oe(debug_data_oe),
   .converter_inputs(converter_inputs), .audio_serial_location(audio_serial_location),
   .periph_pin_in(periph_pin_in), .debug_data_in(debug_data_in),
   .debug_clock_in(debug_clock_in), .conv_trigger_in(conv_trigger_in)
);
`default_nettype wire

// *** pmx_pads.sv ***
// partner: pad wires shared by the block and external devices
`timescale 1ns/1ps
`default_nettype none
module pmx_pads (
   input  wire logic        sys_clk,
   input  wire logic [20:0] pad_out,
   input  wire logic [20:0] pad_oe,
   input  wire logic [20:0] ext_val,
   input  wire logic [20:0] ext_oe,
   output logic      [20:0] pad_in
);
   logic [20:0] last = 21'h000000;
   logic [20:0] float;
   // no pull on pins 8 and 9, so a floating level there is unpredictable
   assign float = 21'h1FFCFF | (~last & 21'h000300);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                   | (~pad_oe & ~ext_oe & float);
   always @(posedge sys_clk) last <= pad_in;
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench: register access, routing and precedence of the pin mux
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pmx_pkg::*;
   logic             sys_clk, rst_b, aloc, lfo, dbg, dbg_o, dbg_oe;
   pmx_sfr_req_t     req;
   pmx_prec_t        prec;
   pmx_drive_t [5:0] drv;
   logic [7:0]       rdata, ain;
   logic [20:0]      pin, pout, poe, fsel, dir, ext_val, ext_oe;
   logic [1:0]       umode;
   logic [5:0]       pen;
   logic [7:0]       rd_q[$];
   logic [62:0]      pad_q[$];
   logic [31:0]      rs = 32'hC60A;
   logic [31:0]      r;
   int               mismatches, compares;
   pmx_pin_mux DUT (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
      .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_analog(), .port_function_select(fsel),
      .port_direction(dir), .prec(prec), .usart_uart_mode(umode), .periph_enable(pen),
      .audio_serial_location(aloc), .analog_input_enable(ain), .low_freq_osc_select(lfo),
      .debug_active(dbg), .debug_data_out(dbg_o), .debug_data_oe(dbg_oe), .periph_drive(drv),
      .periph_pin_in(), .converter_inputs(), .debug_data_in(), .debug_clock_in(),
      .conv_trigger_in());
   pmx_pads u_pads (.sys_clk(sys_clk), .pad_out(pout), .pad_oe(poe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pad_in(pin));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic bad(input logic [41:0] g, input logic [41:0] e);
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
   endtask
   task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) bad(42'(g), 42'(e));
   endtask
   task automatic cmp_pad(input logic [62:0] x);
      compares++;
      if ({pout & x[62:42], poe} !== x[41:0]) bad({pout & x[62:42], poe}, x[41:0]);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
      @(negedge sys_clk);
      req = '{addr:a, rd:1'b1, rmw:m, default:'0};
      rd_q.push_back(e);
      @(negedge sys_clk);
      req = '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b,
                     input logic [2:0] i);
      @(negedge sys_clk);
      req = '{addr:a, wr:!b, bit_wr:b, wdata:d, bit_idx:i, bit_val:d[0], default:'0};
      @(negedge sys_clk);
      req = '0;
   endtask
   // only peripherals in dm drive, so a wrong winner shows as a dropped enable
   task automatic prio(input logic [7:0] loc, input logic [5:0] en, input logic [1:0] um,
                       input logic [5:0] pr, input logic [5:0] dm, input logic [20:0] e);
      wr(PMX_ADDR_LOCSEL, loc, 1'b0, 3'h0);
      pen = en;
      umode = um;
      prec = pr;
      for (int p = 0; p < 6; p++) drv[p] = dm[p] ? 8'hFF : 8'h00;
      @(negedge sys_clk);
      pad_q.push_back({e, e, e});
   endtask
   task automatic route(input int p, input logic l);
      logic [20:0] m, o;
      int lb[6] = '{0, 1, 6, 5, 4, 7};
      m = '0;
      o = '0;
      r = rnd();
      wr(PMX_ADDR_LOCSEL, 8'(l) << lb[p], 1'b0, 3'h0);
      pen = 6'h01 << p;
      aloc = l;
      drv = '0;
      drv[p] = {r[3:0], 4'hF};
      for (int s = 0; s < 4; s++) begin
         if (PMX_SIG_USED[p][s] && PMX_MAP[p][l][s] != PMX_NONE) begin
            m[PMX_MAP[p][l][s]] = 1'b1;
            o[PMX_MAP[p][l][s]] = r[s];
         end
      end
      @(negedge sys_clk);
      pad_q.push_back({m, o, m});
   endtask
   // ------------------------------------------------------------
   // clock, monitor, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      #2;
      if (req.rd === 1'b1) cmp_rd(rdata, rd_q.pop_front());
      while (pad_q.size() > 0) cmp_pad(pad_q.pop_front());
   end
   initial begin
      #100000;
      mismatches++;
      results();
   end
   initial begin
      rst_b = 1'b0;
      {req, prec, drv, ain, fsel, dir, ext_val, ext_oe, umode, pen} = '0;
      {aloc, dbg, dbg_o, dbg_oe} = '0;
      lfo = 1'b1;
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      rd(PMX_ADDR_PORT0, 1'b1, 8'hFF);
      rd(PMX_ADDR_PORT1, 1'b1, 8'hFF);
      rd(PMX_ADDR_PORT2, 1'b1, 8'h1F);
      rd(PMX_ADDR_LOCSEL, 1'b1, 8'h00);
      wr(PMX_ADDR_LOCSEL, 8'hFF, 1'b0, 3'h0);
      rd(PMX_ADDR_LOCSEL, 1'b1, 8'h73);
      wr(8'h33, 8'h5A, 1'b0, 3'h0);
      rd(8'h33, 1'b1, 8'h00);
      wr(PMX_ADDR_PORT2, 8'h00, 1'b1, 3'h2);
      wr(PMX_ADDR_PORT2, 8'h00, 1'b1, 3'h5);
      rd(PMX_ADDR_PORT2, 1'b1, 8'h1B);
      r = rnd();
      dir = 21'h00FF00;
      wr(PMX_ADDR_PORT1, r[7:0], 1'b0, 3'h0);
      @(negedge sys_clk);
      pad_q.push_back({21'h00FF00, 5'h0, r[7:0], 8'h0, 21'h00FF00});
      rd(PMX_ADDR_PORT1, 1'b0, r[7:0]);
      wr(PMX_ADDR_PORT1, 8'h00, 1'b1, 3'h7);
      rd(PMX_ADDR_PORT1, 1'b1, {1'b0, r[6:0]});
      dir = '0;
      fsel = 21'h1FFFFF;
      for (int p = 0; p < 6; p++) begin
         route(p, 1'b0);
         route(p, 1'b1);
      end
      prio(8'h00, 6'h03, 2'h0, 6'b000000, 6'h01, 21'h00003C);
      prio(8'h00, 6'h03, 2'h0, 6'b010000, 6'h02, 21'h00003C);
      prio(8'h00, 6'h03, 2'h3, 6'b000000, 6'h02, 21'h000030);
      prio(8'h00, 6'h05, 2'h0, 6'b100000, 6'h04, 21'h00001C);
      prio(8'h00, 6'h05, 2'h0, 6'b110000, 6'h04, 21'h00001C);
      prio(8'h02, 6'h03, 2'h0, 6'b000000, 6'h03, 21'h00F03C);
      prio(8'h03, 6'h03, 2'h0, 6'b000000, 6'h01, 21'h003C00);
      prio(8'h01, 6'h09, 2'h1, 6'b000000, 6'h08, 21'h000800);
      prio(8'h03, 6'h03, 2'h0, 6'b001000, 6'h02, 21'h00F000);
      prio(8'h41, 6'h05, 2'h0, 6'b000001, 6'h04, 21'h000700);
      prio(8'h22, 6'h0A, 2'h0, 6'b000100, 6'h08, 21'h00C000);
      prio(8'h40, 6'h14, 2'h0, 6'b000010, 6'h10, 21'h000300);
      @(negedge sys_clk);
      {fsel, pen, lfo, dbg, ext_oe} = {21'h0, 6'h0, 1'b0, 1'b1, 21'h010000};
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         {ain, dbg_o, dbg_oe, ext_val} = {r[7:0], r[8], r[9], r[20:0]};
         @(negedge sys_clk);
         pad_q.push_back({{3'h0, r[9], 17'h0}, {3'h0, r[9] & r[8], 17'h0}, {3'h0, r[9], 17'h0}});
         @(negedge sys_clk);
      end
      repeat (2) @(negedge sys_clk);
      results();
   end
endmodule
`default_nettype wire
